// file: rtl/sensor_regs.sv
// Bus-side register bank for external diode trim, averaging and identity
// Overview of operation
// R1: Trim register holds six-bit ideality code in low bits for external channel.
// R2: Trim register bits 7 and 6 always read zero.
// R3: Trim code resets to 12h.
// R4: Diode model maps codes 08h..37h to factors 0.9949..1.0566.
// R5: Transistor model maps the same codes to 0.9869..1.0486, 12h gives 1.0000.
// R6: Host should program trim 15h for 45 nm substrate transistors.
// R7: Averaging control applies only to the external diode channel results.
// R8: Filter field 00 off, 01 and 10 level one, 11 level two.
// R9: Averaging control resets to 00h; bits 7 to 2 read zero.
// R10: Read-only register FDh returns a fixed product code.
// R11: Read-only register FEh returns a fixed maker code.
// R12: Read-only register FFh returns a fixed die revision code.
// R13: Writes to the three identity registers are ignored.
module sensor_regs #(
   parameter logic [6:0] SLAVE_ADDR   = 7'h4c,
   parameter logic [7:0] PRODUCT_CODE   = 8'ha5,  // Arbitrary value
   parameter logic [7:0] MAKER_ID     = 8'h3c,  // Arbitrary value
   parameter logic [7:0] REVISION_ID  = 8'h01   // Arbitrary value
) (
   input  wire logic                                 clock,
   input  wire logic                                 srst,
   input  wire logic                                 smclk_in,
   input  wire logic                                 smdata_in,
   output      logic                                 smdata_out,
   output      logic                                 smdata_oe,
   output      sensor_regs_pkg::ext_cfg_s            ext_cfg,
   output      logic [sensor_regs_pkg::FILT_W-1:0]   filt_field,
   output      logic [sensor_regs_pkg::FACTOR_W-1:0] diode_factor,
   output      logic [sensor_regs_pkg::FACTOR_W-1:0] bjt_factor
);

   logic [1:0]                  pins_s;
   logic                        scl_s;
   logic                        sda_s;
   logic                        scl_d_r;
   logic                        sda_d_r;
   logic                        scl_rise;
   logic                        scl_fall;
   logic                        start_cond;
   logic                        stop_cond;

   sensor_regs_pkg::bus_state_e state_r;
   sensor_regs_pkg::bus_state_e state_nxt;
   logic [3:0]                  cnt_r;
   logic [3:0]                  cnt_nxt;
   logic [7:0]                  shift_r;
   logic [7:0]                  shift_nxt;
   logic [7:0]                  ptr_r;
   logic [7:0]                  ptr_nxt;
   logic                        rw_r;
   logic                        rw_nxt;
   logic                        nack_r;
   logic                        nack_nxt;
   logic                        oe_r;
   logic                        oe_nxt;
   sensor_regs_pkg::ext_cfg_s   cfg_r;
   sensor_regs_pkg::ext_cfg_s   cfg_nxt;
   logic [1:0]                  filt_r;
   logic [1:0]                  filt_nxt;
   logic [7:0]                  rd_val;

   // Filter field to averaging level
   function automatic sensor_regs_pkg::filt_level_e filt_decode(input logic [1:0] f);
      if (f == sensor_regs_pkg::FILT_CODE_OFF)
         return sensor_regs_pkg::FILT_OFF;                            // R8
      else if (f == sensor_regs_pkg::FILT_CODE_L2)
         return sensor_regs_pkg::FILT_LEVEL2;                         // R8
      else
         return sensor_regs_pkg::FILT_LEVEL1;                         // R8
   endfunction

   // Read data for a register pointer
   function automatic logic [7:0] rd_byte(input logic [7:0] p,
                                          input logic [5:0] trim,
                                          input logic [1:0] filt);
      if (p == sensor_regs_pkg::OFS_DIODE_IDEALITY_TRIM)
         return {2'h0, trim};                                         // R2
      else if (p == sensor_regs_pkg::OFS_AVERAGING_CONTROL)
         return {6'h00, filt};                                        // R9
      else if (p == sensor_regs_pkg::OFS_PRODUCT_CODE)
         return PRODUCT_CODE;                                           // R10
      else if (p == sensor_regs_pkg::OFS_MAKER_CODE)
         return MAKER_ID;                                             // R11
      else if (p == sensor_regs_pkg::OFS_DIE_REVISION)
         return REVISION_ID;                                          // R12
      else
         return sensor_regs_pkg::UNMAPPED_READ;
   endfunction

   pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clock (clock),
      .srst  (srst),
      .pin   ({smclk_in, smdata_in}),
      .level (pins_s)
   );

   ideality_lut u_ideality_lut (
      .trim_code          (cfg_r.trim),
      .clock              (clock),
      .srst               (srst),
      .diode_factor       (diode_factor),
      .bjt_factor         (bjt_factor)
   );

   // Line events from synchronised levels
   always_comb
   begin
      scl_s      = pins_s[1];
      sda_s      = pins_s[0];
      scl_rise   = scl_s & ~scl_d_r;
      scl_fall   = ~scl_s & scl_d_r;
      start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
      stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;
      rd_val     = rd_byte(ptr_r, cfg_r.trim, filt_r);
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // Protocol engine and register writes
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      shift_nxt = shift_r;
      ptr_nxt   = ptr_r;
      rw_nxt    = rw_r;
      nack_nxt  = nack_r;
      oe_nxt    = oe_r;
      cfg_nxt   = cfg_r;
      filt_nxt  = filt_r;
      if (start_cond)
      begin
         state_nxt = sensor_regs_pkg::ST_ADDR;
         cnt_nxt   = '0;
         oe_nxt    = 1'b0;
      end
      else if (stop_cond)
      begin
         state_nxt = sensor_regs_pkg::ST_IDLE;
         oe_nxt    = 1'b0;
      end
      else
      begin
         case (state_r)
            sensor_regs_pkg::ST_ADDR,
            sensor_regs_pkg::ST_CMD,
            sensor_regs_pkg::ST_WDATA:
            begin
               if (scl_rise && cnt_r != sensor_regs_pkg::BYTE_BITS)
               begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  cnt_nxt   = cnt_r + 4'h1;
               end
               else if (scl_fall && cnt_r == sensor_regs_pkg::BYTE_BITS)
               begin
                  cnt_nxt = '0;
                  if (state_r == sensor_regs_pkg::ST_ADDR)
                  begin
                     if (shift_r[7:1] == SLAVE_ADDR)
                     begin
                        rw_nxt    = shift_r[0];
                        oe_nxt    = 1'b1;
                        state_nxt = sensor_regs_pkg::ST_ADDR_ACK;
                     end
                     else
                        state_nxt = sensor_regs_pkg::ST_HOLD;
                  end
                  else if (state_r == sensor_regs_pkg::ST_CMD)
                  begin
                     ptr_nxt   = shift_r;
                     oe_nxt    = 1'b1;
                     state_nxt = sensor_regs_pkg::ST_CMD_ACK;
                  end
                  else
                  begin
                     if (ptr_r == sensor_regs_pkg::OFS_DIODE_IDEALITY_TRIM)
                        cfg_nxt.trim = shift_r[5:0];                  // R1
                     else if (ptr_r == sensor_regs_pkg::OFS_AVERAGING_CONTROL)
                        filt_nxt = shift_r[1:0];                      // R7
                     // Identity and unmapped offsets drop the data  // R13
                     oe_nxt    = 1'b1;
                     state_nxt = sensor_regs_pkg::ST_WDATA_ACK;
                  end
               end
            end
            sensor_regs_pkg::ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (rw_r)
                  begin
                     shift_nxt = rd_val;
                     cnt_nxt   = 4'h1;
                     oe_nxt    = ~rd_val[7];
                     state_nxt = sensor_regs_pkg::ST_RDATA;
                  end
                  else
                  begin
                     oe_nxt    = 1'b0;
                     state_nxt = sensor_regs_pkg::ST_CMD;
                  end
               end
            end
            sensor_regs_pkg::ST_CMD_ACK:
            begin
               if (scl_fall)
               begin
                  oe_nxt    = 1'b0;
                  state_nxt = sensor_regs_pkg::ST_WDATA;
               end
            end
            sensor_regs_pkg::ST_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  oe_nxt    = 1'b0;
                  state_nxt = sensor_regs_pkg::ST_HOLD;
               end
            end
            sensor_regs_pkg::ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (cnt_r == sensor_regs_pkg::BYTE_BITS)
                  begin
                     oe_nxt    = 1'b0;
                     state_nxt = sensor_regs_pkg::ST_RACK;
                  end
                  else
                  begin
                     shift_nxt = {shift_r[6:0], 1'b0};
                     oe_nxt    = ~shift_r[6];
                     cnt_nxt   = cnt_r + 4'h1;
                  end
               end
            end
            sensor_regs_pkg::ST_RACK:
            begin
               if (scl_rise)
                  nack_nxt = sda_s;
               else if (scl_fall)
               begin
                  if (nack_r)
                     state_nxt = sensor_regs_pkg::ST_HOLD;
                  else
                  begin
                     // Master ack repeats the same register
                     shift_nxt = rd_val;
                     cnt_nxt   = 4'h1;
                     oe_nxt    = ~rd_val[7];
                     state_nxt = sensor_regs_pkg::ST_RDATA;
                  end
               end
            end
            default:
            begin
               oe_nxt = 1'b0;
            end
         endcase
      end
      cfg_nxt.level = filt_decode(filt_nxt);                          // R8
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r    <= sensor_regs_pkg::ST_IDLE;
         cnt_r      <= '0;
         shift_r    <= '0;
         ptr_r      <= '0;
         rw_r       <= 1'b0;
         nack_r     <= 1'b0;
         oe_r       <= 1'b0;
         cfg_r.trim <= sensor_regs_pkg::TRIM_RESET;                   // R3
         cfg_r.level <= sensor_regs_pkg::FILT_OFF;                    // R9
         filt_r     <= sensor_regs_pkg::FILT_RESET;                   // R9
         smdata_out <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         shift_r    <= shift_nxt;
         ptr_r      <= ptr_nxt;
         rw_r       <= rw_nxt;
         nack_r     <= nack_nxt;
         oe_r       <= oe_nxt;
         cfg_r      <= cfg_nxt;
         filt_r     <= filt_nxt;
         smdata_out <= 1'b0;
      end
   end

   // Open-drain data: only ever pulls low
   always_comb
   begin
      smdata_oe  = oe_r;
      ext_cfg    = cfg_r;
      filt_field = filt_r;
   end

endmodule // sensor_regs

// file: rtl/sensor_regs_pkg.sv
// Shared constants, types and lookup table for the sensor register bank
package sensor_regs_pkg;

   localparam int  REG_W       = 8;
   localparam int  TRIM_W      = 6;
   localparam int  FILT_W      = 2;
   localparam int  FACTOR_W    = 16;

   // Register offsets
   localparam logic [7:0] OFS_DIODE_IDEALITY_TRIM = 8'h27;
   localparam logic [7:0] OFS_AVERAGING_CONTROL   = 8'h40;
   localparam logic [7:0] OFS_PRODUCT_CODE        = 8'hfd;
   localparam logic [7:0] OFS_MAKER_CODE          = 8'hfe;
   localparam logic [7:0] OFS_DIE_REVISION        = 8'hff;

   // Reset values and unmapped read value
   localparam logic [5:0] TRIM_RESET    = 6'h12;
   localparam logic [1:0] FILT_RESET    = 2'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Filter field encodings
   localparam logic [1:0] FILT_CODE_OFF = 2'h0;
   localparam logic [1:0] FILT_CODE_L2  = 2'h3;

   // Bus framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int         ADDR_W    = 7;

   // Trim lookup range and model offset (factor in units of 0.0001)
   localparam logic [5:0]  TRIM_CODE_MIN = 6'h08;
   localparam logic [5:0]  TRIM_CODE_MAX = 6'h37;
   localparam logic [15:0] BJT_OFFSET    = 16'h0050;
   localparam int          LUT_DEPTH     = 48;

   localparam logic [15:0] DIODE_FACTOR [0:LUT_DEPTH-1] = '{
      16'h26dd, 16'h26ea, 16'h26f7, 16'h2704, 16'h2711, 16'h271e, 16'h272b, 16'h2738,
      16'h2745, 16'h2752, 16'h2760, 16'h276d, 16'h277a, 16'h2787, 16'h2795, 16'h27a2,
      16'h27af, 16'h27bc, 16'h27c9, 16'h27d8, 16'h27e4, 16'h27f2, 16'h27ff, 16'h280d,
      16'h281b, 16'h2828, 16'h2835, 16'h2842, 16'h284f, 16'h285c, 16'h2869, 16'h2876,
      16'h2883, 16'h2890, 16'h289d, 16'h28aa, 16'h28b7, 16'h28c4, 16'h28d1, 16'h28de,
      16'h28eb, 16'h28f8, 16'h2905, 16'h2912, 16'h291f, 16'h292c, 16'h2939, 16'h2946
   };

   typedef enum logic [1:0] {
      FILT_OFF,
      FILT_LEVEL1,
      FILT_LEVEL2
   } filt_level_e;

   typedef struct packed {
      logic [TRIM_W-1:0] trim;
      filt_level_e       level;
   } ext_cfg_s;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RACK,
      ST_HOLD
   } bus_state_e;

endpackage

// file: rtl/pin_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
module pin_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] pin,
   output      logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] level_nxt;

   always_comb
   begin
      meta_nxt  = pin;
      level_nxt = meta_r;
   end

   // Idle bus lines float high
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         meta_r <= '1;
         level  <= '1;
      end
      else
      begin
         meta_r <= meta_nxt;
         level  <= level_nxt;
      end
   end

endmodule // pin_sync

// file: rtl/ideality_lut.sv
// Registered lookup of ideality factor for both sensor models
module ideality_lut (
   input  wire logic [sensor_regs_pkg::TRIM_W-1:0]   trim_code,
   input  wire logic                                 clock,
   input  wire logic                                 srst,
   output      logic [sensor_regs_pkg::FACTOR_W-1:0] diode_factor,
   output      logic [sensor_regs_pkg::FACTOR_W-1:0] bjt_factor
);

   logic [5:0]  code_c;
   logic [5:0]  idx;
   logic [15:0] diode_nxt;
   logic [15:0] bjt_nxt;

   // Codes outside the table clamp to its ends
   always_comb
   begin
      code_c = trim_code;
      if (code_c < sensor_regs_pkg::TRIM_CODE_MIN)
         code_c = sensor_regs_pkg::TRIM_CODE_MIN;
      else if (code_c > sensor_regs_pkg::TRIM_CODE_MAX)
         code_c = sensor_regs_pkg::TRIM_CODE_MAX;
      idx       = code_c - sensor_regs_pkg::TRIM_CODE_MIN;
      diode_nxt = sensor_regs_pkg::DIODE_FACTOR[idx];                 // R4
      bjt_nxt   = diode_nxt - sensor_regs_pkg::BJT_OFFSET;            // R5
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         diode_factor <= '0;
         bjt_factor   <= '0;
      end
      else
      begin
         diode_factor <= diode_nxt;
         bjt_factor   <= bjt_nxt;
      end
   end

endmodule // ideality_lut

// file: bench/sensor_regs_checker.sv
// Port assertions for the sensor register bank
module sensor_regs_checker (
   input wire logic                      clock,
   input wire logic                      srst,
   input wire logic                      smclk_in,
   input wire logic                      smdata_in,
   input wire logic                      smdata_out,
   input wire logic                      smdata_oe,
   input wire sensor_regs_pkg::ext_cfg_s ext_cfg,
   input wire logic [1:0]                filt_field,
   input wire logic [15:0]               diode_factor,
   input wire logic [15:0]               bjt_factor
);
   timeunit 1ns;
   timeprecision 1ps;

   sensor_regs_pkg::filt_level_e exp_level;
   logic                         trim_ok;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   always_comb
   begin
      exp_level = sensor_regs_pkg::FILT_LEVEL1;
      if (filt_field == 2'h0)
         exp_level = sensor_regs_pkg::FILT_OFF;
      else if (filt_field == 2'h3)
         exp_level = sensor_regs_pkg::FILT_LEVEL2;
   end
   assign trim_ok = (ext_cfg.trim >= 6'h08) && (ext_cfg.trim <= 6'h37);

   sequence settled_s;
      !srst ##1 !srst ##1 !srst;
   endsequence
   sequence cfg_write_s;
      !srst ##1 $changed({ext_cfg, filt_field});
   endsequence

   trim_reset_a: assert property ($fell(srst) |-> ext_cfg.trim == 6'h12)
      else $error("trim not at default after reset");
   filt_reset_a: assert property ($fell(srst) |-> filt_field == 2'h0 && !ext_cfg.level)
      else $error("averaging not off after reset");
   level_map_a: assert property (ext_cfg.level == exp_level)
      else $error("averaging level does not match field");
   write_on_ack_a: assert property (cfg_write_s |-> $rose(smdata_oe))
      else $error("configuration changed outside a write acknowledge");
   factor_follow_a: assert property (settled_s ##0 ($changed(ext_cfg.trim) && trim_ok
      && $past(trim_ok)) |=> $changed(diode_factor))
      else $error("factor did not follow trim change");
   default_factor_a: assert property (settled_s ##0 (ext_cfg.trim == 6'h12
      && $stable(ext_cfg.trim)) |-> diode_factor == 16'h2760 && bjt_factor == 16'h2710)
      else $error("default trim gives wrong factors");
   model_offset_a: assert property (settled_s |-> bjt_factor == diode_factor - 16'h0050)
      else $error("transistor factor not offset from diode factor");
   diode_range_a: assert property (settled_s |-> diode_factor >= 16'h26dd
      && diode_factor <= 16'h2946)
      else $error("diode factor out of table range");
   open_drain_a: assert property (!smdata_out)
      else $error("data pin driven high");
endmodule // sensor_regs_checker

bind sensor_regs sensor_regs_checker i_checker (
   .clock(clock), .srst(srst), .smclk_in(smclk_in), .smdata_in(smdata_in),
   .smdata_out(smdata_out), .smdata_oe(smdata_oe), .ext_cfg(ext_cfg),
   .filt_field(filt_field), .diode_factor(diode_factor), .bjt_factor(bjt_factor)
);

// file: bench/smbus_host.sv
// Two-wire bus host model with open-drain data
module smbus_host (
   input  wire logic clock,
   input  wire logic sda_in,
   output      logic scl,
   output      logic sda_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      scl = 1'b1;
      sda_out = 1'b1;
   end

   // Clock phases kept at twelve cycles, above the ten-cycle minimum
   task automatic pause();
      repeat (12) @(negedge clock);
   endtask

   task automatic start_cond();
      sda_out = 1'b1;
      pause();
      scl = 1'b1;
      pause();
      sda_out = 1'b0;
      pause();
      scl = 1'b0;
   endtask

   task automatic stop_cond();
      sda_out = 1'b0;
      pause();
      scl = 1'b1;
      pause();
      sda_out = 1'b1;
      pause();
   endtask

   // Ninth bit always released: device acknowledge in, host not-acknowledge out
   task automatic xfer(input logic [7:0] b, output logic [7:0] seen, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         sda_out = (i == 0) ? 1'b1 : b[i-1];
         pause();
         scl = 1'b1;
         pause();
         if (i == 0)
            ack = sda_in;
         else
            seen[i-1] = sda_in;
         scl = 1'b0;
      end
   endtask

   task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
                            input logic [7:0] data, output logic [2:0] acks);
      logic [7:0] seen;
      start_cond();
      xfer({addr, 1'b0}, seen, acks[2]);
      xfer(cmd, seen, acks[1]);
      xfer(data, seen, acks[0]);
      stop_cond();
   endtask

   task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd,
                           output logic [7:0] data, output logic [2:0] acks);
      logic nack;
      logic [7:0] seen;
      start_cond();
      xfer({addr, 1'b0}, seen, acks[2]);
      xfer(cmd, seen, acks[1]);
      start_cond();
      xfer({addr, 1'b1}, seen, acks[0]);
      xfer(8'hff, data, nack);
      stop_cond();
   endtask
endmodule // smbus_host

// file: bench/testbench.sv
// Self-checking bench for the sensor register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [6:0] DEV_ADDR = 7'h4c;
   localparam logic [7:0] ID_VAL[3] = '{8'h6b, 8'h92, 8'h0e};  // Arbitrary values
   localparam logic [7:0] ID_OFS[3] = '{8'hfd, 8'hfe, 8'hff};
   localparam logic [7:0] CODES[4] = '{8'h08, 8'h12, 8'h15, 8'h37};
   localparam logic [15:0] DIODE_EXP[4] = '{16'h26dd, 16'h2760, 16'h2787, 16'h2946};
   localparam logic [15:0] BJT_EXP[4] = '{16'h268d, 16'h2710, 16'h2737, 16'h28f6};

   logic                      clock;
   logic                      srst;
   logic                      scl;
   logic                      host_sda;
   logic                      smdata_out;
   logic                      smdata_oe;
   logic                      wire_sda;
   sensor_regs_pkg::ext_cfg_s ext_cfg;
   logic [1:0]                filt_field;
   logic [15:0]               diode_factor;
   logic [15:0]               bjt_factor;
   sensor_regs_pkg::filt_level_e lvl;
   int                        mismatches;
   int                        comparisons;
   logic [2:0]                foreign_acks;

   // Pulled-up wire, low when either side pulls
   assign wire_sda = host_sda & ~(smdata_oe & ~smdata_out);

   sensor_regs #(.SLAVE_ADDR(DEV_ADDR), .PRODUCT_CODE(ID_VAL[0]), .MAKER_ID(ID_VAL[1]),
                 .REVISION_ID(ID_VAL[2])) i_dut (
      .clock(clock), .srst(srst), .smclk_in(scl), .smdata_in(wire_sda),
      .smdata_out(smdata_out), .smdata_oe(smdata_oe), .ext_cfg(ext_cfg),
      .filt_field(filt_field), .diode_factor(diode_factor), .bjt_factor(bjt_factor)
   );
   smbus_host i_host (.clock(clock), .sda_in(wire_sda), .scl(scl), .sda_out(host_sda));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
      logic [2:0] acks;
      i_host.write_reg(DEV_ADDR, cmd, data, acks);
      check("write acks", {13'h0000, acks}, 16'h0000);
   endtask

   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      logic [7:0] data;
      logic [2:0] acks;
      i_host.read_reg(DEV_ADDR, cmd, data, acks);
      check("read acks", {13'h0000, acks}, 16'h0000);
      check($sformatf("reg %h", cmd), {8'h00, data}, {8'h00, exp});
   endtask

   // Reset held five cycles, then idle bus settles through the synchronisers
   task automatic apply_reset();
      srst = 1'b1;
      repeat (5) @(negedge clock);
      srst = 1'b0;
      repeat (4) @(negedge clock);
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      mismatches = 0;
      comparisons = 0;
      apply_reset();
      check("trim", {10'h000, ext_cfg.trim}, 16'h0012);
      rd(8'h27, 8'h12);
      rd(8'h40, 8'h00);
      check("diode", diode_factor, 16'h2760);
      check("bjt", bjt_factor, 16'h2710);
      wr(8'h27, 8'hff);
      rd(8'h27, 8'h3f);
      check("trim", {10'h000, ext_cfg.trim}, 16'h003f);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h27, CODES[i]);
         rd(8'h27, CODES[i]);
         check("diode", diode_factor, DIODE_EXP[i]);
         check("bjt", bjt_factor, BJT_EXP[i]);
      end
      for (int f = 0; f < 4; f++)
      begin
         lvl = (f == 0) ? sensor_regs_pkg::FILT_OFF :
               (f == 3) ? sensor_regs_pkg::FILT_LEVEL2 : sensor_regs_pkg::FILT_LEVEL1;
         wr(8'h40, {6'h3f, f[1:0]});
         rd(8'h40, {6'h00, f[1:0]});
         check("field", {14'h0000, filt_field}, {14'h0000, f[1:0]});
         check("level", {14'h0000, ext_cfg.level}, {14'h0000, lvl});
         check("trim", {10'h000, ext_cfg.trim}, 16'h0037);
      end
      for (int i = 0; i < 3; i++)
      begin
         rd(ID_OFS[i], ID_VAL[i]);
         wr(ID_OFS[i], ~ID_VAL[i]);
         rd(ID_OFS[i], ID_VAL[i]);
      end
      i_host.write_reg(DEV_ADDR ^ 7'h01, 8'h27, 8'h08, foreign_acks);
      check("foreign acks", {13'h0000, foreign_acks}, 16'h0007);
      rd(8'h27, 8'h37);
      apply_reset();
      check("trim", {10'h000, ext_cfg.trim}, 16'h0012);
      check("field", {14'h0000, filt_field}, 16'h0000);
      check("level", {14'h0000, ext_cfg.level}, 16'h0000);
      check("diode", diode_factor, 16'h2760);
      rd(8'h27, 8'h12);
      rd(8'h40, 8'h00);
      rd(8'h80, 8'h00);
      give_verdict();
   end

   initial
   begin
      repeat (90000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
endmodule // testbench
